// *** include/zbsram_pkg.sv ***
// Shared constants and carriers for the pipelined zero-latency SRAM core.
// Assumes a single 200 MHz clock and an active-low asynchronous reset.
package zbsram_pkg;
	localparam int ZBS_ADDR_W = 10;
	localparam int ZBS_DATA_W = 36;
	localparam int ZBS_BYTES = 4;
	localparam int ZBS_FIFO_DEPTH = 4;
	localparam int ZBS_CLK_PERIOD_PS = 5000;
	localparam int ZBS_SLEEP_MAX_PS = 2 * ZBS_CLK_PERIOD_PS;
	localparam int ZBS_SLEEP_CYC = ZBS_SLEEP_MAX_PS / ZBS_CLK_PERIOD_PS;
	localparam logic [1:0] ZBS_SYNC_RST = 2'h0;
	localparam logic ZBS_BURST_LINEAR = 1'h0;
	localparam logic ZBS_BURST_INTLV = 1'h1;

	typedef enum logic [1:0] {
		ZBS_AWAKE = 2'h0,
		ZBS_ASLEEP = 2'h1,
		ZBS_ENTER = 2'h2,
		ZBS_LEAVE = 2'h3
	} zbs_sleep_e;

	typedef struct packed {
		logic [ZBS_ADDR_W-1:0] addr;
		logic [ZBS_DATA_W-1:0] data;
		logic [ZBS_BYTES-1:0] bmask;
	} zbs_wr_s;
endpackage : zbsram_pkg

// *** rtl/zbs_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module zbs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Fill side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [PW:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready = (cnt_r != (PW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
		end
		if (pop) begin
			rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + (PW+1)'(1);
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - (PW+1)'(1);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage has no reset; only pointers and the count carry control state.
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end
endmodule : zbs_fifo

// *** rtl/zbs_sram_core.sv ***
// Pipelined zero-latency synchronous burst SRAM core with sleep mode.
// Assumes bus inputs synchronous to mclk; sleep_request is synchronised.
//
// Overview of operation
// - Sleep request high deselects, enters power-down.
// - Power-down lasts exactly while sleep request high; the core lags the request by three clocks at entry and exit.
// - In power-down ignore inputs, tri-state data.
// - Inputs ignored within two clocks of sleep; the core ignores them from the fourth clock.
// - Inputs sampled within two clocks after wake; the core samples from the fourth clock.
// - Address captured on enabled load edges.
// - Select active only when 0, 0, 1.
// - Burst order input: 0 linear, 1 interleaved.
// - Gated clock edge holds all pipeline state.
// - No array write on a gated edge.
// - Reads forward data from pending write register.
// - Burst counter advances every continue cycle of a selected burst.
// - Write only bytes whose strobes are low.
`timescale 1ns/1ps
module zbs_sram_core
	import zbsram_pkg::*;
#(
	parameter int AW = zbsram_pkg::ZBS_ADDR_W,
	parameter int DEPTH = zbsram_pkg::ZBS_FIFO_DEPTH
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Power, stall and burst-order control.
	input wire logic sleep_request,
	input wire logic clock_gate_n,
	input wire logic burst_order,
	// Command bus.
	input wire logic chip_select_n,
	input wire logic chip_select2_n,
	input wire logic chip_select_high,
	input wire logic burst_continue_or_load,
	input wire logic read_write_n,
	input wire logic [AW-1:0] addr,
	input wire logic [zbsram_pkg::ZBS_BYTES-1:0] byte_strobe_n,
	input wire logic output_enable_n,
	// Data pins.
	input wire logic [zbsram_pkg::ZBS_DATA_W-1:0] dq_in,
	output logic [zbsram_pkg::ZBS_DATA_W-1:0] dq_out,
	output logic dq_oe,
	// Status.
	output logic power_down,
	output logic write_ready
);
	import zbsram_pkg::*;
	localparam int DW = ZBS_DATA_W;
	localparam int NB = ZBS_BYTES;
	localparam int BW = DW / NB;
	localparam int WW = AW + DW + NB;

	logic [DW-1:0] mem_r [2**AW];

	function automatic logic [1:0] burst_seq(input logic [1:0] base,
		input logic [1:0] step, input logic mode);
		burst_seq = (mode == ZBS_BURST_INTLV) ? (base ^ step) : base + step;
	endfunction : burst_seq

	// Sleep request synchroniser and sleep state machine.
	logic [1:0] slp_sync_r, slp_sync_nxt;
	zbs_sleep_e slp_r, slp_nxt;
	logic asleep;

	always_comb begin
		slp_sync_nxt = {slp_sync_r[0], sleep_request};
		slp_nxt = slp_r;
		case (slp_r)
			ZBS_AWAKE: if (slp_sync_r[1]) slp_nxt = ZBS_ASLEEP;
			ZBS_ENTER: slp_nxt = ZBS_ASLEEP;
			ZBS_ASLEEP: if (!slp_sync_r[1]) slp_nxt = ZBS_AWAKE;
			ZBS_LEAVE: slp_nxt = ZBS_AWAKE;
			default: slp_nxt = ZBS_AWAKE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			slp_sync_r <= ZBS_SYNC_RST;
			slp_r <= ZBS_AWAKE;
		end else begin
			slp_sync_r <= slp_sync_nxt;
			slp_r <= slp_nxt;
		end
	end

	assign asleep = (slp_r == ZBS_ASLEEP);
	assign power_down = asleep;

	// Command decode; a gated or sleeping edge takes nothing.
	logic run, cs_act, load, cont, wr_cmd, rd_cmd;
	assign run = !clock_gate_n && !asleep;
	assign cs_act = !chip_select_n && !chip_select2_n
		&& chip_select_high;

	// Burst registers and first pipeline stage.
	logic [AW-1:0] base_r, base_nxt;
	logic [1:0] step_r, step_nxt;
	logic act_r, act_nxt, wr_r, wr_nxt, mode_r, mode_nxt;
	logic s1_v_r, s1_v_nxt, s1_wr_r, s1_wr_nxt;
	logic [AW-1:0] s1_a_r, s1_a_nxt;
	logic [NB-1:0] s1_m_r, s1_m_nxt;
	logic [AW-1:0] cur_a;

	assign load = run && !burst_continue_or_load;
	assign cont = run && burst_continue_or_load && act_r;
	assign wr_cmd = load ? (cs_act && !read_write_n) : (cont && wr_r);
	assign rd_cmd = load ? (cs_act && read_write_n) : (cont && !wr_r);
	assign cur_a = load ? addr : {base_r[AW-1:2],
		burst_seq(base_r[1:0], step_r + 2'h1, mode_r)};

	always_comb begin
		base_nxt = base_r;
		step_nxt = step_r;
		act_nxt = act_r;
		wr_nxt = wr_r;
		mode_nxt = mode_r;
		s1_v_nxt = s1_v_r;
		s1_wr_nxt = s1_wr_r;
		s1_a_nxt = s1_a_r;
		s1_m_nxt = s1_m_r;
		if (asleep) begin
			act_nxt = 1'b0;
			s1_v_nxt = 1'b0;
		end else if (run) begin
			if (load) begin
				base_nxt = addr;
				step_nxt = 2'h0;
				act_nxt = cs_act;
				wr_nxt = !read_write_n;
				mode_nxt = burst_order;
			end else if (cont) begin
				step_nxt = step_r + 2'h1;
			end
			s1_v_nxt = rd_cmd || wr_cmd;
			s1_wr_nxt = wr_cmd;
			s1_a_nxt = cur_a;
			s1_m_nxt = ~byte_strobe_n;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			base_r <= '0;
			step_r <= 2'h0;
			act_r <= 1'b0;
			wr_r <= 1'b0;
			mode_r <= ZBS_BURST_LINEAR;
			s1_v_r <= 1'b0;
			s1_wr_r <= 1'b0;
			s1_a_r <= '0;
			s1_m_r <= '0;
		end else begin
			base_r <= base_nxt;
			step_r <= step_nxt;
			act_r <= act_nxt;
			wr_r <= wr_nxt;
			mode_r <= mode_nxt;
			s1_v_r <= s1_v_nxt;
			s1_wr_r <= s1_wr_nxt;
			s1_a_r <= s1_a_nxt;
			s1_m_r <= s1_m_nxt;
		end
	end

	// Write data arrives one edge after its command and queues in the FIFO.
	logic wq_in_v, wq_out_v, wq_out_rdy, wq_in_rdy;
	zbs_wr_s wq_in, wq_out;
	assign wq_in_v = run && s1_v_r && s1_wr_r && (s1_m_r != '0);
	assign wq_in.addr = s1_a_r;
	assign wq_in.data = dq_in;
	assign wq_in.bmask = s1_m_r;
	// A sleeping core ignores the gate pin, so the queue holds its entry.
	assign wq_out_rdy = !clock_gate_n && !asleep;
	assign write_ready = wq_in_rdy;

	zbs_fifo #(.WIDTH(WW), .DEPTH(DEPTH)) u_wq (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(wq_in_v),
		.in_ready(wq_in_rdy),
		.in_data(wq_in),
		.out_valid(wq_out_v),
		.out_ready(wq_out_rdy),
		.out_data(wq_out)
	);

	always_ff @(posedge mclk) begin
		if (wq_out_v && wq_out_rdy) begin
			for (int b = 0; b < NB; b++) begin
				if (wq_out.bmask[b]) begin
					mem_r[wq_out.addr][b*BW +: BW] <=
						wq_out.data[b*BW +: BW];
				end
			end
		end
	end

	// Read result merges the array with a write still in flight.
	logic [DW-1:0] rd_word;
	always_comb begin
		rd_word = mem_r[s1_a_r];
		if (wq_out_v && wq_out.addr == s1_a_r) begin
			for (int b = 0; b < NB; b++) begin
				if (wq_out.bmask[b]) begin
					rd_word[b*BW +: BW] = wq_out.data[b*BW +: BW];
				end
			end
		end
	end

	logic [DW-1:0] q_r, q_nxt;
	logic qv_r, qv_nxt;
	always_comb begin
		q_nxt = q_r;
		qv_nxt = qv_r;
		if (asleep) begin
			qv_nxt = 1'b0;
		end else if (run) begin
			qv_nxt = s1_v_r && !s1_wr_r;
			if (s1_v_r && !s1_wr_r) begin
				q_nxt = rd_word;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q_r <= '0;
			qv_r <= 1'b0;
		end else begin
			q_r <= q_nxt;
			qv_r <= qv_nxt;
		end
	end

	assign dq_out = q_r;
	assign dq_oe = qv_r && !output_enable_n && !asleep;

	// Counts array writes so the gated-edge check can see a drain.
	logic [7:0] wr_cnt_r, wr_cnt_nxt;
	always_comb begin
		wr_cnt_nxt = wr_cnt_r;
		if (wq_out_v && wq_out_rdy) begin
			wr_cnt_nxt = wr_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_cnt_r <= 8'h00;
		end else begin
			wr_cnt_r <= wr_cnt_nxt;
		end
	end

	a_sleep_entry: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(slp_sync_r[1]) |=> asleep)
		else $error("Sleep not entered after request.");
	a_sleep_exit: assert property (@(posedge mclk) disable iff (!rst_n)
		asleep && !slp_sync_r[1] |=> !asleep)
		else $error("Sleep not left after request fell.");
	a_sleep_tristate: assert property (@(posedge mclk) disable iff (!rst_n)
		asleep |-> !dq_oe ##1 (!qv_r && !s1_v_r))
		else $error("Data driven during sleep.");
	a_stall_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		clock_gate_n && !asleep |=> $stable(q_r) && $stable(step_r))
		else $error("Pipeline moved on a gated edge.");
	a_stall_nowrite: assert property (@(posedge mclk) disable iff (!rst_n)
		clock_gate_n |=> $stable(wr_cnt_r))
		else $error("Write drained on a gated edge.");
	a_desel_tristate: assert property (@(posedge mclk) disable iff (!rst_n)
		load && !cs_act ##1 run |=> !qv_r)
		else $error("Outputs driven after deselect.");
	a_burst_step: assert property (@(posedge mclk) disable iff (!rst_n)
		cont && !asleep |=> step_r == $past(step_r) + 2'h1)
		else $error("Burst counter did not advance.");
	a_load_addr: assert property (@(posedge mclk) disable iff (!rst_n)
		load |=> base_r == $past(addr))
		else $error("Address not captured on load.");
	a_read_valid: assert property (@(posedge mclk) disable iff (!rst_n)
		load && cs_act && read_write_n ##1 run |=> qv_r)
		else $error("Read data not presented.");
endmodule : zbs_sram_core

// *** testbench/testbench.sv ***
// Self-checking bench for the pipelined SRAM core with sleep mode.
// Assumes the controller model drives the bus from this bench.
`timescale 1ns/1ps
module testbench;
	import zbsram_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic sleep_request = 1'b0;
	logic chip_select_n, chip_select2_n, chip_select_high;
	logic burst_continue_or_load, read_write_n, burst_order;
	logic clock_gate_n, output_enable_n, dq_oe, power_down, write_ready;
	logic [ZBS_ADDR_W-1:0] addr;
	logic [ZBS_BYTES-1:0] byte_strobe_n, c_bs;
	logic [ZBS_DATA_W-1:0] dq_in, dq_out, c_d, wpend_d;
	logic [ZBS_DATA_W-1:0] mem [0:7];
	logic [ZBS_DATA_W-1:0] p_d [0:1];
	logic p_rd [0:1];
	logic [2:0] c_sel, c_a, base;
	logic c_cont, c_rw, c_bo, c_take, act, brw, bmd, wpend, bo;
	int cnt;
	int num_errors = 0;
	int check_count = 0;

	zbs_ctrl_model u_ctl (.chip_select_n(chip_select_n),
		.chip_select2_n(chip_select2_n), .chip_select_high(chip_select_high),
		.burst_continue_or_load(burst_continue_or_load),
		.read_write_n(read_write_n), .burst_order(burst_order),
		.clock_gate_n(clock_gate_n), .output_enable_n(output_enable_n),
		.addr(addr), .byte_strobe_n(byte_strobe_n), .dq_in(dq_in));
	zbs_sram_core #(.AW(ZBS_ADDR_W), .DEPTH(ZBS_FIFO_DEPTH)) u_dut (
		.mclk(mclk), .rst_n(rst_n), .sleep_request(sleep_request),
		.clock_gate_n(clock_gate_n), .burst_order(burst_order),
		.chip_select_n(chip_select_n), .chip_select2_n(chip_select2_n),
		.chip_select_high(chip_select_high),
		.burst_continue_or_load(burst_continue_or_load),
		.read_write_n(read_write_n), .addr(addr),
		.byte_strobe_n(byte_strobe_n), .output_enable_n(output_enable_n),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.power_down(power_down), .write_ready(write_ready));

	always #2.5 mclk = ~mclk;

	task automatic chk(input string what, input logic [35:0] seen,
		input logic [35:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	// Applies a command the core has taken to the reference memory.
	task automatic take();
		logic [2:0] ea;
		logic [35:0] w;
		if (!c_cont) begin
			act = (c_sel == 3'h1);
			base = c_a;
			cnt = 0;
			brw = c_rw;
			bmd = c_bo;
		end else begin
			cnt++;
		end
		ea = bmd ? (base ^ 3'(cnt & 3)) : {base[2], 2'(base[1:0] + cnt)};
		p_rd[1] = p_rd[0];
		p_d[1] = p_d[0];
		p_rd[0] = act && brw;
		wpend = act && !brw;
		wpend_d = c_d;
		w = mem[ea];
		for (int i = 0; i < 4; i++)
			if (wpend && !c_bs[i]) w[i*9 +: 9] = c_d[i*9 +: 9];
		mem[ea] = w;
		p_d[0] = w;
	endtask : take

	task automatic step(input logic [2:0] sel, input logic cont,
		input logic rw, input logic [2:0] a, input logic [3:0] bs,
		input logic gn, input logic oe);
		logic [35:0] d;
		logic oe_exp;
		d = {$urandom(), 4'($urandom())};
		@(posedge mclk);
		#1;
		if (c_take) begin
			take();
			oe_exp = p_rd[1] && !output_enable_n && power_down !== 1'b1;
			chk("dq_oe", dq_oe, oe_exp);
			if (p_rd[1]) chk("dq_out", dq_out, p_d[1]);
		end
		chk("write_ready", write_ready, 1'b1);
		if (power_down === 1'b1) chk("dq_oe asleep", dq_oe, 1'b0);
		c_take = !gn && (power_down !== 1'b1);
		{c_sel, c_cont, c_rw, c_a, c_bs, c_bo, c_d} = {sel, cont, rw, a, bs, bo, d};
		u_ctl.drive(sel, cont, rw, {7'h0, a}, bs, gn, oe, bo, wpend_d, wpend);
	endtask : step

	task automatic wait_pd(input logic v);
		int n;
		for (n = 0; n < 3 && power_down !== v; n++)
			step(3'h6, 1'b0, 1'b1, 3'h0, 4'hf, 1'b0, 1'b0);
		chk("power_down", power_down, v);
		if (power_down !== v) give_verdict();
	endtask : wait_pd

	initial begin
		#20000;
		num_errors++;
		give_verdict();
	end

	initial begin
		void'($urandom(32'hc46b));
		{bo, wpend, wpend_d, c_take, act, cnt} = '0;
		p_rd = '{1'b0, 1'b0};
		u_ctl.drive(3'h6, 1'b0, 1'b1, 10'h0, 4'hf, 1'b0, 1'b0, 1'b0, '0, 1'b1);
		repeat (16) @(posedge mclk);
		#1;
		chk("reset dq_oe", dq_oe, 1'b0);
		chk("reset power_down", power_down, 1'b0);
		chk("reset write_ready", write_ready, 1'b1);
		chk("reset dq_out", dq_out, 36'h0);
		rst_n = 1'b1;
		for (int i = 0; i < 8; i++) step(3'h1, 1'b0, 1'b0, 3'(i), 4'h0, 1'b0, 1'b0);
		for (int i = 0; i < 400; i++) begin
			bo = 1'($urandom());
			step(($urandom() % 3 != 0) ? 3'h1 : 3'($urandom()), 1'($urandom()),
				1'($urandom()), 3'($urandom()),
				($urandom() % 2 != 0) ? 4'h0 : 4'($urandom()),
				($urandom() % 4 == 0), ($urandom() % 8 == 0));
		end
		// Drain the pipeline before sleeping.
		repeat (3) step(3'h6, 1'b0, 1'b1, 3'h0, 4'hf, 1'b0, 1'b0);
		sleep_request = 1'b1;
		wait_pd(1'b1);
		for (int i = 0; i < 6; i++) begin
			step(3'h1, 1'b0, 1'b0, 3'h3, 4'h0, 1'b0, 1'b0);
			chk("power_down held", power_down, 1'b1);
		end
		sleep_request = 1'b0;
		wait_pd(1'b0);
		// Only reads and deselects once awake.
		for (int i = 0; i < 8; i++) step(3'h1, 1'b0, 1'b1, 3'(i), 4'hf, 1'b0, 1'b0);
		repeat (3) step(3'h6, 1'b0, 1'b1, 3'h0, 4'hf, 1'b0, 1'b0);
		give_verdict();
	end
endmodule : testbench

// *** testbench/zbs_ctrl_model.sv ***
// Behavioural memory controller driving the synchronous SRAM bus.
// Assumes the bench calls drive once per cycle, just after a rising edge.
`timescale 1ns/1ps
module zbs_ctrl_model
	import zbsram_pkg::*;
(
	// Select and command lines.
	output logic chip_select_n,
	output logic chip_select2_n,
	output logic chip_select_high,
	output logic burst_continue_or_load,
	output logic read_write_n,
	output logic burst_order,
	output logic clock_gate_n,
	output logic output_enable_n,
	output logic [zbsram_pkg::ZBS_ADDR_W-1:0] addr,
	output logic [zbsram_pkg::ZBS_BYTES-1:0] byte_strobe_n,
	// Write data.
	output logic [zbsram_pkg::ZBS_DATA_W-1:0] dq_in
);
	// Every line is held for the whole cycle, selects included.
	task automatic drive(input logic [2:0] sel, input logic cont,
		input logic rw, input logic [ZBS_ADDR_W-1:0] a, input logic [3:0] bs,
		input logic gn, input logic oe, input logic bo,
		input logic [ZBS_DATA_W-1:0] d, input logic due);
		{chip_select_n, chip_select2_n, chip_select_high} = sel;
		burst_continue_or_load = cont;
		read_write_n = rw;
		addr = a;
		byte_strobe_n = bs;
		clock_gate_n = gn;
		output_enable_n = oe;
		burst_order = bo;
		// Data that is not due is scrambled so a stale sample shows.
		dq_in = (due && !gn) ? d : ~dq_in;
	endtask : drive
endmodule : zbs_ctrl_model
